// *** rtl/tbd_pkg.sv ***
package tbd_pkg;
   localparam int unsigned TBD_WIDTH       = 10;
   localparam int unsigned TBD_MAX_SLAVES  = 4;
   localparam logic        TBD_REF_SEL_RST = 1'b0;
   localparam logic        TBD_SEL_REF10   = 1'b0;
   localparam logic        TBD_SEL_CLK125  = 1'b1;
   localparam int unsigned TBD_SYNC_STAGES = 2;
   typedef enum logic {TBD_ROLE_SLAVE, TBD_ROLE_MASTER} tbd_role_type;
endpackage

// *** rtl/tbd_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a vector; only the second stage leaves
module tbd_sync
   import tbd_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic [TBD_WIDTH-1:0] d,
   output logic      [TBD_WIDTH-1:0] q
);
   logic [TBD_WIDTH-1:0] meta_reg;

   // First stage feeds second stage only
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_reg <= '0;
         q        <= '0;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule // tbd_sync
`default_nettype wire

// *** rtl/tbd_distributor.sv ***
`timescale 1ns/1ps
`default_nettype none
// Timing bus distributor: master resyncs and drives, slave listens
module tbd_distributor
   import tbd_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 master_mode,
   input  wire logic                 ref_sel,
   input  wire logic                 ref10_in,
   input  wire logic                 front_en,
   input  wire logic                 back_en,
   input  wire logic [TBD_WIDTH-1:0] timing_in,
   input  wire logic [TBD_WIDTH-1:0] front_i,
   output logic      [TBD_WIDTH-1:0] front_o,
   output logic      [TBD_WIDTH-1:0] front_oe,
   input  wire logic [TBD_WIDTH-1:0] back_i,
   output logic      [TBD_WIDTH-1:0] back_o,
   output logic      [TBD_WIDTH-1:0] back_oe,
   output logic      [TBD_WIDTH-1:0] timing_out,
   output logic                      is_master
);
   logic [TBD_WIDTH-1:0] in_sync;
   logic [TBD_WIDTH-1:0] drive_reg;
   logic [TBD_WIDTH-1:0] drive_next;
   logic [TBD_WIDTH-1:0] rx_sync;
   logic [TBD_WIDTH-1:0] out_next;
   logic [1:0]           ref_reg;
   logic                 ref_sel_reg;
   tbd_role_type         role_reg;
   wire                  ref_rise;
   wire                  upd_en;
   wire                  drive_front;
   wire                  drive_back;
   wire  [TBD_WIDTH-1:0] bus_pins;

   // Role test shared by the drive gates, the status output and the checks
   function automatic logic role_is_master(input tbd_role_type role);
      return (role == TBD_ROLE_MASTER);
   endfunction

   // Master inputs brought into the clock domain first
   // Two stages cost two cycles of latency but give a full cycle to settle,
   // which matters because the external timing lines have no phase relation
   tbd_sync u_in_sync
   (
      .clk (clk),
      .rst (rst),
      .d   (timing_in),
      .q   (in_sync)
   );

   // Readback path: whichever enabled bus pins are actually seen
   // Only one bus is watched; with both enabled the front ribbon wins, so a
   // broken backplane link goes unnoticed by the master in that setup
   assign bus_pins = front_en ? front_i : back_i;

   tbd_sync u_rx_sync
   (
      .clk (clk),
      .rst (rst),
      .d   (bus_pins),
      .q   (rx_sync)
   );

   // Selection and role latch; ref defaults to 10 MHz after reset
   // The reference level is kept one cycle back so a rise can be spotted
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ref_reg     <= 2'h0;
         ref_sel_reg <= TBD_REF_SEL_RST;
         role_reg    <= TBD_ROLE_SLAVE;
      end
      else
      begin
         ref_reg     <= {ref_reg[0], ref10_in};
         ref_sel_reg <= ref_sel;
         role_reg    <= master_mode ? TBD_ROLE_MASTER : TBD_ROLE_SLAVE;
      end
   end

   // Update enable: one pulse per rising 10 MHz edge, or every 125 MHz cycle
   // Updating only on reference edges lines all cards up on the same
   // 100 ns grid, at the price of up to one reference period of delay
   assign ref_rise   = ref_reg[0] & ~ref_reg[1];
   assign upd_en     = (ref_sel_reg == TBD_SEL_CLK125) | ref_rise;
   assign drive_next = upd_en ? in_sync : drive_reg;

   // Slave output is plain registered bus; master reads own pins too
   // Taking the pins, not drive_reg, gives the master the slaves' timing
   assign out_next   = rx_sync;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         drive_reg  <= '0;
         timing_out <= '0;
      end
      else
      begin
         drive_reg  <= drive_next;
         timing_out <= out_next;
      end
   end

   // Only a master enables drivers; each bus gated by its own enable
   // A second master on one bus would fight; the role input must prevent it
   assign drive_front = role_is_master(role_reg) & front_en;
   assign drive_back  = role_is_master(role_reg) & back_en;

   // All ten lines treated alike; meaning left to the application
   genvar g;
   generate
      for (g = 0; g < TBD_WIDTH; g++)
      begin : g_line
         assign front_oe[g] = drive_front;
         assign back_oe[g]  = drive_back;
      end
   endgenerate

   // Both buses carry the one registered value
   assign front_o   = drive_reg;
   assign back_o    = drive_reg;
   assign is_master = role_is_master(role_reg);

   // Slave never drives either bus
   a_slave_tristate: assert property (@(posedge clk) disable iff (rst)
      (role_reg == TBD_ROLE_SLAVE) |-> (front_oe == '0 && back_oe == '0))
      else $error("slave drives bus");

   // Master with front enabled drives every front line
   a_master_front_drive: assert property (@(posedge clk) disable iff (rst)
      (is_master && front_en) |-> (&front_oe))
      else $error("master not driving front bus");

   // Backplane enable alone decides backplane drive
   a_back_drive: assert property (@(posedge clk) disable iff (rst)
      (is_master && back_en && !front_en) |-> (&back_oe))
      else $error("backplane not driven");

   // Backplane driven alongside the front bus as well
   a_back_master: assert property (@(posedge clk) disable iff (rst)
      (is_master && back_en) |-> (&back_oe))
      else $error("backplane not driven with front");

   // In 10 MHz mode the driven value holds between reference edges
   a_ref10_hold: assert property (@(posedge clk) disable iff (rst)
      (ref_sel_reg == TBD_SEL_REF10 && !ref_rise) |=> $stable(drive_reg))
      else $error("bus changed off reference edge");

   // In 10 MHz mode a reference edge loads the synchronised inputs
   a_ref10_update: assert property (@(posedge clk) disable iff (rst)
      (ref_sel_reg == TBD_SEL_REF10 && ref_rise) |=> (drive_reg == $past(in_sync)))
      else $error("bus missed reference edge");

   // A reference rise is a single-cycle pulse
   a_ref_pulse: assert property (@(posedge clk) disable iff (rst)
      ref_rise |=> !ref_rise)
      else $error("reference pulse too long");

   // In 125 MHz mode the bus follows synchronised inputs next cycle
   a_clk125_follow: assert property (@(posedge clk) disable iff (rst)
      (ref_sel_reg == TBD_SEL_CLK125) |=> (drive_reg == $past(in_sync)))
      else $error("bus not tracking inputs");

   // Reset leaves a slave with the 10 MHz reference and quiet outputs
   a_reset_default: assert property (@(posedge clk) disable iff (rst)
      $past(rst) |-> (ref_sel_reg == TBD_REF_SEL_RST && !is_master && timing_out == '0))
      else $error("wrong state after reset");

   // Master input reaches drive exactly three cycles later in fast mode
   a_input_path: assert property (@(posedge clk) disable iff (rst)
      (ref_sel_reg == TBD_SEL_CLK125 && ref_sel == TBD_SEL_CLK125)[*4]
      |-> (drive_reg == $past(timing_in, 3)))
      else $error("master input path broken");

   // Output comes from pins three cycles back, not internal value; the
   // pins are picked on the first of those cycles, hence four of enable
   a_readback: assert property (@(posedge clk) disable iff (rst)
      (front_en)[*4] |-> (timing_out == $past(front_i, 3)))
      else $error("readback not from pins");

   // Without the front bus the view comes from the backplane pins
   a_back_readback: assert property (@(posedge clk) disable iff (rst)
      (!front_en)[*4] |-> (timing_out == $past(back_i, 3)))
      else $error("readback not from backplane");

   // Role follows the mode input one cycle later
   a_role_follow: assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> (is_master == $past(master_mode)))
      else $error("role not following mode");

   // A disabled bus is never driven
   a_bus_off: assert property (@(posedge clk) disable iff (rst)
      (!front_en |-> front_oe == '0) and (!back_en |-> back_oe == '0))
      else $error("disabled bus driven");

   // All lines of one bus share one enable
   a_oe_uniform: assert property (@(posedge clk) disable iff (rst)
      (front_oe == '0 || &front_oe) && (back_oe == '0 || &back_oe))
      else $error("bus lines enabled unevenly");

   // Driven value is the same on both buses
   a_same_value: assert property (@(posedge clk) disable iff (rst)
      (front_o == back_o))
      else $error("bus values differ");
endmodule // tbd_distributor
`default_nettype wire

// *** tb/tbd_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
// Far card on both buses; it drives only while it holds the master role
module tbd_peer
   import tbd_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 peer_master,
   input  wire logic [TBD_WIDTH-1:0] peer_val,
   output logic      [TBD_WIDTH-1:0] peer_o,
   output logic      [TBD_WIDTH-1:0] peer_oe
);
   // Registered like a real driver, so the value lands one cycle late
   always_ff @(posedge clk)
   begin
      peer_o  <= peer_val;
      peer_oe <= {TBD_WIDTH{peer_master}};
   end
endmodule // tbd_peer
`default_nettype wire

// *** tb/test_timing_bus_distributor.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_timing_bus_distributor;
   import tbd_pkg::*;
   typedef logic [TBD_WIDTH-1:0] tbd_vec_type;
   logic        clk = 0, rst = 1, mm = 0, rs = TBD_SEL_REF10, r10 = 0;
   logic        fe = 0, be = 0, pm = 0, ism;
   tbd_vec_type tin = '0, pv = '0, prev, flt = '0;
   tbd_vec_type fi, fo, foe, bi, bo, boe, tout, po, poe;
   int          fails = 0, n_compared = 0, cyc = 0;
   always #4 clk = ~clk;
   // Undriven lines toggle so a stale value can never pass for a match
   always @(posedge clk) flt <= ~flt;
   assign fi = (foe & fo) | (poe & po) | (~foe & ~poe & flt);
   assign bi = (boe & bo) | (poe & po) | (~boe & ~poe & flt);
   tbd_distributor dut (.clk(clk), .rst(rst), .master_mode(mm), .ref_sel(rs),
      .ref10_in(r10), .front_en(fe), .back_en(be), .timing_in(tin), .front_i(fi),
      .front_o(fo), .front_oe(foe), .back_i(bi), .back_o(bo), .back_oe(boe),
      .timing_out(tout), .is_master(ism));
   tbd_peer peer (.clk(clk), .peer_master(pm), .peer_val(pv), .peer_o(po), .peer_oe(poe));
   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000) begin fails++; complete_run(); end
   end
   task automatic chk(string nm, tbd_vec_type exp, tbd_vec_type got);
      n_compared++;
      if (got !== exp) begin fails++; $display("mismatch %s exp %h got %h", nm, exp, got); end
   endtask
   task automatic wt(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic complete_run;
      if (fails == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Inputs change on falling edges only
   initial
   begin
      void'($urandom(1));
      wt(20);
      rst = 0;
      chk("front_oe", '0, foe);
      mm = 1; fe = 1; rs = TBD_SEL_CLK125;
      wt(2);
      chk("is_master", 1, ism);
      chk("front_oe", '1, foe);
      chk("back_oe", '0, boe);
      for (int i = 0; i < 8; i++)
      begin
         tin = (i == 0) ? '1 : tbd_vec_type'($urandom);
         wt(3);
         chk("front_o", tin, fo);
         wt(3);
         chk("timing_out", tin, tout);
      end
      // Backplane in place of the ribbon, then both together
      fe = 0; be = 1; tin = tbd_vec_type'($urandom);
      wt(7);
      chk("front_oe", '0, foe);
      chk("back_oe", '1, boe);
      chk("back_o", tin, bo);
      chk("timing_out", tin, tout);
      fe = 1;
      wt(2);
      chk("front_oe", '1, foe);
      // Slow reference: hold until a rising reference edge
      rs = TBD_SEL_REF10; prev = tin; tin = ~prev;
      wt(12);
      chk("front_o", prev, fo);
      r10 = 1;
      wt(10);
      chk("front_o", tin, fo);
      r10 = 0;
      // Slave role: listen to the peer card
      mm = 0; pm = 1; pv = tbd_vec_type'($urandom);
      wt(8);
      chk("is_master", 0, ism);
      chk("front_oe", '0, foe);
      chk("back_oe", '0, boe);
      chk("timing_out", pv, tout);
      complete_run();
   end
endmodule // test_timing_bus_distributor
`default_nettype wire
